// >>> logic/mfw_consts.svh
// constants of the two-level table walk front end
`ifndef MFW_CONSTS_SVH
`define MFW_CONSTS_SVH
`define MFW_CR_CTRL     4'h1
`define MFW_CR_TTB      4'h2
`define MFW_CR_DAC      4'h3
`define MFW_CR_FSR      4'h5
`define MFW_CR_FAR      4'h6
`define MFW_CR_TLBOP    4'h8
`define MFW_CR_LOCK     4'hA
`define MFW_CR_PID      4'hD
`define MFW_OP2_DATA    3'h0
`define MFW_OP2_INSTR   3'h1
`define MFW_OP2_ALL     3'h0
`define MFW_OP2_ONE     3'h1
`define MFW_BIT_M       0
`define MFW_BIT_A       1
`define MFW_BIT_S       8
`define MFW_BIT_R       9
`define MFW_CTRL_MASK   32'h0000_0303
`define MFW_TTB_MASK    32'hFFFF_C000
`define MFW_LOCK_MASK   32'h1C00_0001
`define MFW_FS_MASK     32'h0000_00FF
`define MFW_PID_LSB     25
`define MFW_D_FAULT     2'h0
`define MFW_D_COARSE    2'h1
`define MFW_D_SECTION   2'h2
`define MFW_D_FINE      2'h3
`define MFW_F_ALIGN     4'h1
`define MFW_F_TRANS_S   4'h5
`define MFW_F_TRANS_P   4'h7
`define MFW_F_DOM_S     4'h9
`define MFW_F_DOM_P     4'hB
`define MFW_F_PERM_S    4'hD
`define MFW_F_PERM_P    4'hF
`define MFW_DAC_NONE    2'h0
`define MFW_DAC_CLIENT  2'h1
`define MFW_DAC_MGR     2'h3
`endif

// >>> logic/mfw_pkg.sv
// types of the two-level table walk front end
package mfw_pkg;
    typedef enum logic [1:0] {
        MFW_IDLE  = 2'b00,
        MFW_L1    = 2'b01,
        MFW_L2    = 2'b10,
        MFW_CHECK = 2'b11
    } mfw_state_t;
    typedef logic [31:0] mfw_word_t;
    typedef logic [3:0]  mfw_creg_t;
endpackage : mfw_pkg

// >>> logic/mfw_mmu_walk.sv
// mmu register file, relocation, tlb and hardware table walk
// ----------------------------------------------------------------------
// Functional notes
// - table base holds bits 31..14; software keeps the table 16KB aligned
// - domain access register is sixteen two-bit fields, one per domain
// - fault status holds domain in 7..4 and fault type in 3..0
// - fault address captures the modified address of a data abort
// - prefetch abort address goes out on the abort link register
// - tlb operation write invalidates all unpreserved entries or one entry
// - tlb operation register is write-only; all others read and write
// - lockdown uses bits 28..26 and 0 to lock loaded entries
// - hardware updates fault status and address on abort, beside writes
// - control holds mmu enable, alignment check and S and R bits
// - modified addresses map to physical ones with permission checks
// - walk hardware reads the table and loads results into the tlb
// - a walk starts only when the tlb misses
// - table base reads return zero in the low fourteen bits
// - first-level table has 4096 word entries, each one megabyte
// - first fetch address is base 31..14 joined with address 31..20
// - walk starts with level one; pages need one more level-two fetch
// - descriptor low bits: 00 fault, 01 coarse, 10 section, 11 fine
// - addresses below 32MB add pid times 32MB; none while mmu is off
// - after reset the mmu is off and maps nothing
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`include "mfw_consts.svh"
module mfw_mmu_walk (
    // clock, reset, enable
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // coprocessor register access
    input  wire logic              cp_wr,
    input  wire logic              cp_rd,
    input  wire mfw_pkg::mfw_creg_t cp_crn,
    input  wire logic [2:0]        cp_opc2,
    input  wire mfw_pkg::mfw_word_t cp_wdata,
    output      mfw_pkg::mfw_word_t cp_rdata,
    // core translation request
    input  wire logic              core_req,
    input  wire mfw_pkg::mfw_word_t core_va,
    input  wire logic              core_instr,
    input  wire logic              core_write,
    input  wire logic              core_priv,
    input  wire logic              core_word,
    output      logic              core_ack,
    output      logic              core_abort,
    output      mfw_pkg::mfw_word_t core_pa,
    output      mfw_pkg::mfw_word_t abort_link_register,
    // table memory read port
    output      logic              mem_req,
    output      mfw_pkg::mfw_word_t mem_addr,
    input  wire logic              mem_ack,
    input  wire mfw_pkg::mfw_word_t mem_rdata
);
    import mfw_pkg::*;
    localparam int N = 8;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    mfw_word_t  ctrl_q, ttb_q, dac_q, dfs_q, ifs_q, far_q, lock_q;
    logic [6:0] pid_q;
    mfw_state_t st_q;
    mfw_word_t  va_q, rva_q, desc_q;
    logic       wr_q, priv_q, instr_q, walked_q;
    logic [21:0] epa_q;
    logic [3:0] edom_q;
    logic [1:0] eap_q;
    logic       esec_q;
    logic [2:0] rr_q;
    logic       tv_q [N];
    logic       tl_q [N];
    logic [21:0] ttag_q [N];
    logic [21:0] tpa_q [N];
    logic [3:0] tdom_q [N];
    logic [1:0] tap_q [N];
    logic       tsec_q [N];

    // ------------------------------------------------------------------
    // relocation and lookup
    // ------------------------------------------------------------------
    wire        mmu_on = ctrl_q[`MFW_BIT_M];
    wire        low32m = (core_va[31:`MFW_PID_LSB] == 7'h00);
    wire mfw_word_t rva = (mmu_on && low32m)
        ? {pid_q, core_va[`MFW_PID_LSB-1:0]} : core_va;
    logic [N-1:0] hitv;
    logic [N-1:0] opv;
    genvar g;
    for (g = 0; g < N; g++) begin : g_cmp
        assign hitv[g] = tv_q[g] && (ttag_q[g] == rva[31:10]);
        assign opv[g]  = tv_q[g] && (ttag_q[g] == cp_wdata[31:10]);
    end
    logic [2:0] hit_idx;
    always_comb begin
        hit_idx = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (hitv[i]) begin
                hit_idx = 3'(i);
            end
        end
    end
    wire tlb_hit = |hitv;
    wire mis_al = ctrl_q[`MFW_BIT_A] && !core_instr && core_word
        && (core_va[1:0] != 2'h0);
    wire take = clk_en && st_q == MFW_IDLE && core_req && !core_ack;

    // ------------------------------------------------------------------
    // descriptor decode
    // ------------------------------------------------------------------
    wire [1:0] d1t = desc_q[1:0];
    wire [1:0] d2t = mem_rdata[1:0];
    wire mfw_word_t l2_addr = (mem_rdata[1:0] == `MFW_D_COARSE)
        ? {mem_rdata[31:10], rva_q[19:12], 2'h0}
        : {mem_rdata[31:12], rva_q[19:10], 2'h0};
    wire l2_bad = d2t == `MFW_D_FAULT
        || (d2t == 2'h3 && d1t == `MFW_D_COARSE);
    wire [1:0] sub = (d2t == 2'h1) ? rva_q[15:14]
        : (d2t == 2'h2) ? rva_q[11:10] : 2'h0;
    wire [1:0] l2_ap = mem_rdata[4'd4 + {1'b0, sub, 1'b0} +: 2];
    wire [21:0] l2_pa = (d2t == 2'h1) ? {mem_rdata[31:16], rva_q[15:10]}
        : (d2t == 2'h2) ? {mem_rdata[31:12], rva_q[11:10]}
        : mem_rdata[31:10];

    // ------------------------------------------------------------------
    // permission check
    // ------------------------------------------------------------------
    wire [1:0] dfield = dac_q[{edom_q, 1'b0} +: 2];
    logic ap_ok;
    always_comb begin
        unique case (eap_q)
            2'h0: ap_ok = !wr_q && (priv_q
                ? (ctrl_q[`MFW_BIT_S] | ctrl_q[`MFW_BIT_R])
                : ctrl_q[`MFW_BIT_R]);
            2'h1: ap_ok = priv_q;
            2'h2: ap_ok = priv_q || !wr_q;
            2'h3: ap_ok = 1'b1;
        endcase
    end
    wire [3:0] chk_fs =
        (dfield == `MFW_DAC_MGR) ? 4'h0
        : (dfield != `MFW_DAC_CLIENT)
            ? (esec_q ? `MFW_F_DOM_S : `MFW_F_DOM_P)
        : ap_ok ? 4'h0 : (esec_q ? `MFW_F_PERM_S : `MFW_F_PERM_P);

    // ------------------------------------------------------------------
    // walk state machine and responses
    // ------------------------------------------------------------------
    logic       fin, fab;
    logic [3:0] ffs, fdom;
    mfw_word_t  fpa;
    always_comb begin
        fin = 1'b0; fab = 1'b0; ffs = 4'h0; fdom = 4'h0;
        fpa = {epa_q, va_q[9:0]};
        if (take && (mis_al || !mmu_on)) begin
            fin = 1'b1; fab = mis_al; ffs = `MFW_F_ALIGN; fpa = rva;
        end else if (clk_en && st_q == MFW_L1 && mem_ack
                     && mem_rdata[1:0] == `MFW_D_FAULT) begin
            fin = 1'b1; fab = 1'b1; ffs = `MFW_F_TRANS_S;
        end else if (clk_en && st_q == MFW_L2 && mem_ack && l2_bad) begin
            fin = 1'b1; fab = 1'b1; ffs = `MFW_F_TRANS_P;
            fdom = desc_q[8:5];
        end else if (clk_en && st_q == MFW_CHECK) begin
            fin = 1'b1; fab = chk_fs != 4'h0; ffs = chk_fs;
            fdom = edom_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q <= MFW_IDLE; mem_req <= 1'b0; mem_addr <= 32'h0;
            walked_q <= 1'b0;
        end else if (clk_en) begin
            unique case (st_q)
                MFW_IDLE: if (take && !fin) begin
                    walked_q <= !tlb_hit;
                    st_q     <= tlb_hit ? MFW_CHECK : MFW_L1;
                    mem_req  <= !tlb_hit;
                    mem_addr <= {ttb_q[31:14], rva[31:20], 2'h0};
                end
                MFW_L1: if (mem_ack) begin
                    mem_req <= mem_rdata[0];
                    mem_addr <= l2_addr;
                    st_q <= (mem_rdata[1:0] == `MFW_D_FAULT) ? MFW_IDLE
                          : mem_rdata[0] ? MFW_L2 : MFW_CHECK;
                end
                MFW_L2: if (mem_ack) begin
                    mem_req <= 1'b0;
                    st_q <= l2_bad ? MFW_IDLE : MFW_CHECK;
                end
                MFW_CHECK: st_q <= MFW_IDLE;
            endcase
        end
    end

    // latched request and current entry
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            va_q <= 32'h0; rva_q <= 32'h0; desc_q <= 32'h0;
            wr_q <= 1'b0; priv_q <= 1'b0; instr_q <= 1'b0;
            epa_q <= 22'h0; edom_q <= 4'h0; eap_q <= 2'h0; esec_q <= 1'b0;
        end else if (clk_en) begin
            if (take) begin
                va_q <= core_va; rva_q <= rva; wr_q <= core_write;
                priv_q <= core_priv; instr_q <= core_instr;
                epa_q <= tpa_q[hit_idx]; edom_q <= tdom_q[hit_idx];
                eap_q <= tap_q[hit_idx]; esec_q <= tsec_q[hit_idx];
            end
            if (st_q == MFW_L1 && mem_ack) begin
                desc_q <= mem_rdata;
                epa_q <= {mem_rdata[31:20], rva_q[19:10]};
                edom_q <= mem_rdata[8:5]; eap_q <= mem_rdata[11:10];
                esec_q <= 1'b1;
            end
            if (st_q == MFW_L2 && mem_ack) begin
                epa_q <= l2_pa; eap_q <= l2_ap; esec_q <= 1'b0;
            end
        end
    end

    // answers to the core
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            core_ack <= 1'b0; core_abort <= 1'b0; core_pa <= 32'h0;
            abort_link_register <= 32'h0;
        end else if (clk_en) begin
            core_ack <= fin;
            core_abort <= fin && fab;
            if (fin) begin
                core_pa <= fpa;
            end
            if (fin && fab && (take ? core_instr : instr_q)) begin
                abort_link_register <= take ? core_va : va_q;
            end
        end else begin
            core_ack <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register file and tlb
    // ------------------------------------------------------------------
    wire wsel = clk_en && cp_wr;
    wire ab_i = fin && fab && (take ? core_instr : instr_q);
    wire ab_d = fin && fab && !(take ? core_instr : instr_q);
    wire [2:0] ld_idx = lock_q[0] ? lock_q[28:26] : rr_q;
    wire ld = clk_en && st_q == MFW_CHECK && walked_q
        && (lock_q[0] || !tl_q[rr_q]);
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_q <= 32'h0; ttb_q <= 32'h0; dac_q <= 32'h0;
            dfs_q <= 32'h0; ifs_q <= 32'h0; far_q <= 32'h0;
            lock_q <= 32'h0; pid_q <= 7'h00;
        end else if (wsel) begin
            unique case (cp_crn)
                `MFW_CR_CTRL: ctrl_q <= cp_wdata & `MFW_CTRL_MASK;
                `MFW_CR_TTB:  ttb_q <= cp_wdata & `MFW_TTB_MASK;
                `MFW_CR_DAC:  dac_q <= cp_wdata;
                `MFW_CR_FSR:
                    if (cp_opc2 == `MFW_OP2_INSTR && !ab_i) begin
                        ifs_q <= cp_wdata & `MFW_FS_MASK;
                    end else if (cp_opc2 == `MFW_OP2_DATA && !ab_d) begin
                        dfs_q <= cp_wdata & `MFW_FS_MASK;
                    end
                `MFW_CR_FAR:  if (!ab_d) far_q <= cp_wdata;
                `MFW_CR_LOCK: lock_q <= cp_wdata & `MFW_LOCK_MASK;
                `MFW_CR_PID:  pid_q <= cp_wdata[31:`MFW_PID_LSB];
                default: ;
            endcase
        end
        if (rst_n && clk_en && ab_d) begin
            dfs_q <= {24'h0, fdom, ffs};
            far_q <= take ? rva : rva_q;
        end
        if (rst_n && clk_en && ab_i) begin
            ifs_q <= {24'h0, fdom, ffs};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rr_q <= 3'h0;
            for (int i = 0; i < N; i++) begin
                tv_q[i] <= 1'b0; tl_q[i] <= 1'b0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < N; i++) begin
                if (cp_wr && cp_crn == `MFW_CR_TLBOP
                    && ((cp_opc2 == `MFW_OP2_ALL && !tl_q[i])
                     || (cp_opc2 == `MFW_OP2_ONE && opv[i]))) begin
                    tv_q[i] <= 1'b0;
                    tl_q[i] <= 1'b0;
                end
            end
            if (ld) begin
                tv_q[ld_idx] <= 1'b1; tl_q[ld_idx] <= lock_q[0];
                ttag_q[ld_idx] <= rva_q[31:10]; tpa_q[ld_idx] <= epa_q;
                tdom_q[ld_idx] <= edom_q; tap_q[ld_idx] <= eap_q;
                tsec_q[ld_idx] <= esec_q;
                rr_q <= rr_q + 3'h1;
            end
        end
    end

    // read data
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cp_rdata <= 32'h0;
        end else if (clk_en && cp_rd) begin
            unique case (cp_crn)
                `MFW_CR_CTRL: cp_rdata <= ctrl_q;
                `MFW_CR_TTB:  cp_rdata <= ttb_q;
                `MFW_CR_DAC:  cp_rdata <= dac_q;
                `MFW_CR_FSR:  cp_rdata <=
                    (cp_opc2 == `MFW_OP2_INSTR) ? ifs_q : dfs_q;
                `MFW_CR_FAR:  cp_rdata <= far_q;
                `MFW_CR_LOCK: cp_rdata <= lock_q;
                `MFW_CR_PID:  cp_rdata <= {pid_q, 25'h0};
                default:      cp_rdata <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_walk_l1_addr: assert property (st_q == MFW_L1 |->
        mem_addr == {ttb_q[31:14], rva_q[31:20], 2'h0})
        else $error("level one fetch address wrong");
    chk_walk_on_miss: assert property (take && !fin && tlb_hit
        |=> st_q == MFW_CHECK && !mem_req)
        else $error("walk started on a tlb hit");
    chk_reloc_low: assert property (take && mmu_on && low32m
        |=> rva_q[31:25] == pid_q && rva_q[24:0] == va_q[24:0])
        else $error("relocation wrong");
    chk_off_flat: assert property (take && !mmu_on && !mis_al
        |=> core_ack && !core_abort && core_pa == va_q)
        else $error("mmu off did not pass address");
    chk_far_data: assert property (ab_d && clk_en
        |=> far_q == rva_q && dfs_q[3:0] == $past(ffs))
        else $error("data abort not recorded");
    chk_prefetch_lr: assert property (ab_i && clk_en
        |=> abort_link_register == va_q && ifs_q[7:0] == $past({fdom, ffs}))
        else $error("prefetch abort not recorded");
    chk_opreg_read: assert property (clk_en && cp_rd
        && cp_crn == `MFW_CR_TLBOP |=> cp_rdata == 32'h0)
        else $error("tlb operation register readable");
    chk_invalid_desc: assert property (st_q == MFW_L1 && mem_ack
        && clk_en && mem_rdata[1:0] == `MFW_D_FAULT
        |=> core_abort && !mem_req ##1 !core_ack)
        else $error("invalid descriptor did not fault");
    chk_ttb_low: assert property (clk_en && cp_rd
        && cp_crn == `MFW_CR_TTB |=> cp_rdata[13:0] == 14'h0)
        else $error("table base low bits not zero");
endmodule : mfw_mmu_walk

// >>> testbench/mfw_table_mem.sv
// table memory model that answers walk descriptor fetches
`timescale 1ns/1ps
module mfw_table_mem (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // answer delay ceiling
    input  wire logic [2:0]  max_wait,
    // walk read port
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output      logic        mem_ack,
    output      logic [31:0] mem_rdata
);
    logic [31:0] words [logic [29:0]];
    logic [2:0]  wait_q;

    task automatic put(input logic [31:0] a, input logic [31:0] d);
        words[a[31:2]] = d;
    endtask : put

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h0;
            wait_q    <= 3'h0;
        end else if (mem_ack) begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_q    <= 3'($urandom_range(32'(max_wait)));
        end else if (mem_req && wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end else if (mem_req) begin
            mem_ack   <= 1'b1;
            mem_rdata <= words.exists(mem_addr[31:2]) ?
                         words[mem_addr[31:2]] : 32'h0;
        end
    end
endmodule : mfw_table_mem

// >>> testbench/mfw_mmu_walk_test.sv
// self-checking bench of the mmu table walk front end
`timescale 1ns/1ps
`include "mfw_consts.svh"
module mfw_mmu_walk_test;
    import mfw_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       cp_wr = 1'b0;
    logic       cp_rd = 1'b0;
    mfw_creg_t  cp_crn = 4'h0;
    logic [2:0] cp_opc2 = 3'h0;
    mfw_word_t  cp_wdata = 32'h0;
    mfw_word_t  cp_rdata;
    logic       core_req = 1'b0;
    mfw_word_t  core_va = 32'h0;
    logic       core_instr = 1'b0;
    logic       core_write = 1'b0;
    logic       core_word = 1'b1;
    logic       core_ack;
    logic       core_abort;
    mfw_word_t  core_pa;
    mfw_word_t  abort_link_register;
    logic       mem_req;
    mfw_word_t  mem_addr;
    logic       mem_ack;
    mfw_word_t  mem_rdata;
    logic [2:0] max_wait = 3'h0;
    int         n_mismatch = 0;
    int         total_checks = 0;
    int         cyc = 0;
    mfw_word_t  fetch_q[$];
    mfw_word_t  ttb;
    logic [6:0] pid;
    mfw_creg_t  rg_crn [8] = '{`MFW_CR_CTRL, `MFW_CR_TTB, `MFW_CR_DAC,
        `MFW_CR_FSR, `MFW_CR_FSR, `MFW_CR_FAR, `MFW_CR_LOCK, `MFW_CR_PID};
    logic [2:0] rg_op [8] = '{3'h0, 3'h0, 3'h0, `MFW_OP2_DATA,
        `MFW_OP2_INSTR, 3'h0, 3'h0, 3'h0};
    mfw_word_t  rg_msk [8] = '{`MFW_CTRL_MASK, `MFW_TTB_MASK, 32'hFFFF_FFFF,
        `MFW_FS_MASK, `MFW_FS_MASK, 32'hFFFF_FFFF, `MFW_LOCK_MASK,
        32'hFE00_0000};

    mfw_mmu_walk dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
        .cp_wr(cp_wr), .cp_rd(cp_rd), .cp_crn(cp_crn), .cp_opc2(cp_opc2),
        .cp_wdata(cp_wdata), .cp_rdata(cp_rdata), .core_req(core_req),
        .core_va(core_va), .core_instr(core_instr),
        .core_write(core_write), .core_priv(1'b1), .core_word(core_word),
        .core_ack(core_ack), .core_abort(core_abort), .core_pa(core_pa),
        .abort_link_register(abort_link_register), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    mfw_table_mem mem_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .max_wait(max_wait), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    always #12.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (rst_n && mem_req && mem_ack)
            fetch_q.push_back(mem_addr);
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task automatic check_word(input mfw_word_t got, input mfw_word_t exp,
                              input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp,
                             input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : check_bit

    task automatic cp_write(input mfw_creg_t crn, input logic [2:0] op,
                            input mfw_word_t d);
        @(posedge clk_sys);
        cp_wr    <= 1'b1;
        cp_crn   <= crn;
        cp_opc2  <= op;
        cp_wdata <= d;
        @(posedge clk_sys);
        cp_wr <= 1'b0;
    endtask : cp_write

    task automatic rd_chk(input mfw_creg_t crn, input logic [2:0] op,
                          input mfw_word_t exp, input string what);
        @(posedge clk_sys);
        cp_rd   <= 1'b1;
        cp_crn  <= crn;
        cp_opc2 <= op;
        @(posedge clk_sys);
        cp_rd <= 1'b0;
        @(negedge clk_sys);
        check_word(cp_rdata, exp, what);
    endtask : rd_chk

    task automatic core_op(input mfw_word_t va, input logic ins,
                           output logic ab);
        int n;
        fetch_q.delete();
        @(posedge clk_sys);
        core_req   <= 1'b1;
        core_va    <= va;
        core_instr <= ins;
        core_write <= 1'($urandom);
        core_word  <= 1'($urandom);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (core_ack !== 1'b1 && n < 400);
        ab = core_abort;
        check_bit(core_ack, 1'b1, "no answer");
        @(posedge clk_sys);
        core_req <= 1'b0;
        repeat (24) @(negedge clk_sys);
    endtask : core_op

    task automatic walk(input int typ, input logic ins, input mfw_word_t va);
        mfw_word_t rva, d1, d2, l1a, l2a, pa;
        logic ab;
        rva = (va < 32'h0200_0000) ? va + {pid, 25'h0} : va;
        l1a = {ttb[31:14], rva[31:20], 2'b00};
        d1 = 32'h0;
        l2a = 32'h0;
        pa = 32'h0;
        d2 = ($urandom & 32'hFFFF_FC3C) | ((typ == 3) ? 32'h3 : 32'h2);
        if (typ == 2) begin
            d1 = ($urandom & 32'hFFF0_0DEC) | 32'h12;
            pa = {d1[31:20], rva[19:0]};
        end else if (typ == 1) begin
            d1 = ($urandom & 32'hFFFF_FDE0) | 32'h11;
            l2a = {d1[31:10], rva[19:12], 2'b00};
            pa = {d2[31:12], rva[11:0]};
        end else if (typ == 3) begin
            d1 = ($urandom & 32'hFFFF_F1E0) | 32'h13;
            l2a = {d1[31:12], rva[19:10], 2'b00};
            pa = {d2[31:10], rva[9:0]};
        end
        mem_i.put(l1a, d1);
        if (typ == 1 || typ == 3)
            mem_i.put(l2a, d2);
        cp_write(`MFW_CR_TLBOP, `MFW_OP2_ALL, 32'h0);
        core_op(va, ins, ab);
        check_bit(ab, typ == 0, "abort");
        check_word(32'(fetch_q.size()), (typ == 0 || typ == 2) ? 32'h1 :
                   32'h2, "fetch count");
        check_word(fetch_q[0], l1a, "level one address");
        if (typ == 0) begin
            rd_chk(`MFW_CR_FSR, ins ? `MFW_OP2_INSTR : `MFW_OP2_DATA, 32'h5,
                   "fault status");
            if (ins)
                check_word(abort_link_register, va, "link");
            else
                rd_chk(`MFW_CR_FAR, 3'h0, rva, "fault addr");
        end else begin
            check_word(core_pa, pa, "physical address");
            if (typ != 2)
                check_word(fetch_q[1], l2a, "level two address");
        end
    endtask : walk
    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        mfw_word_t va, w;
        logic ab;
        void'($urandom(32'hADE9));
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd_chk(rg_crn[i], rg_op[i], 32'h0, "reset value");
        va = $urandom;
        core_op(va, 1'b0, ab);
        check_word(core_pa, va, "mmu off address");
        check_word(32'(fetch_q.size()), 32'h0, "mmu off fetch");
        for (int k = 0; k < 16; k++) begin
            w = $urandom;
            cp_write(rg_crn[k % 8], rg_op[k % 8], w);
            rd_chk(rg_crn[k % 8], rg_op[k % 8], w & rg_msk[k % 8],
                   "readback");
        end
        rd_chk(`MFW_CR_TLBOP, 3'h0, 32'h0, "tlb op read");
        rd_chk(4'h4, 3'h0, 32'h0, "unmapped read");
        ttb = $urandom & `MFW_TTB_MASK;
        pid = 7'($urandom);
        cp_write(`MFW_CR_TTB, 3'h0, ttb);
        cp_write(`MFW_CR_DAC, 3'h0, 32'hFFFF_FFFF);
        cp_write(`MFW_CR_PID, 3'h0, {pid, 25'h0});
        cp_write(`MFW_CR_LOCK, 3'h0, 32'h0);
        cp_write(`MFW_CR_CTRL, 3'h0, 32'h1);
        for (int k = 0; k < 16; k++) begin
            max_wait <= 3'(k % 8);
            va = $urandom;
            if (k[0])
                va = va & 32'h01FF_FFFF;
            walk(k % 4, k[2], va);
        end
        va = $urandom | 32'h8000_0000;
        walk(2, 1'b0, va);
        core_op(va, 1'b0, ab);
        check_word(32'(fetch_q.size()), 32'h0, "hit fetch");
        cp_write(`MFW_CR_TLBOP, `MFW_OP2_ONE, va);
        core_op(va, 1'b0, ab);
        check_word(32'(fetch_q.size()), 32'h1, "refetch");
        cp_write(`MFW_CR_DAC, 3'h0, 32'h0);
        core_op(va, 1'b0, ab);
        check_bit(ab, 1'b1, "domain fault");
        test_done();
    end
endmodule : mfw_mmu_walk_test
